// >>> common/trim_defs.svh
// constants shared by the supply-pulse trim programmer and the trimmed switch
`ifndef TRIM_DEFS_SVH
`define TRIM_DEFS_SVH

// clock
`define CLK_FREQ_HZ      100000000
`define CLK_PERIOD_NS    10

// supply levels, millivolts (minimum of each band)
`define BASE_LEVEL_MV    4500
`define MID_LEVEL_MV     11500
`define HIGH_LEVEL_MV    25000

// programming pulse timing
`define PULSE_MIN_NS     20000
`define GAP_MIN_NS       20000
`define BURN_MIN_US      100
`define BURN_TYP_US      300
`define PULSE_CYC        ((`PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GAP_CYC          ((`GAP_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BURN_CYC         ((`BURN_TYP_US * 1000) / `CLK_PERIOD_NS)

// internal chopper clock
`define CHOP_FREQ_HZ     170000
`define CHOP_EDGE_CYC    (`CLK_FREQ_HZ / (2 * `CHOP_FREQ_HZ))

// trim code and fuses
`define CODE_W           5
`define ADDR_W           6
`define LOCK_ADDR        6'h20
`define OP_BASE_LO_G     12'h03C
`define OP_BASE_HI_G     12'h12C
`define STEP_LO_SHIFT    3
`define STEP_HI_SHIFT    4
`define HYST_G           12'h00F

// programmer registers (byte offsets)
`define REG_CMD          8'h00
`define REG_STATUS       8'h04
`define CMD_OP_LSB       0
`define CMD_OP_MSB       2
`define CMD_CNT_LSB      8
`define CMD_CNT_MSB      13
`define ST_BUSY          0
`define ST_DEV_OUT       1
`define ST_LVL_LSB       2
`define ST_LVL_MSB       3
`define OP_NONE          3'h0
`define OP_KEY           3'h1
`define OP_ADDR          3'h2
`define OP_BURN          3'h3
`define OP_OFF           3'h4
`define KEY_PULSES       6'h03

`endif

// >>> common/trim_pkg.sv
// types shared by both ends of the supply-pulse link
package trim_pkg;
  typedef enum logic [1:0] {LVL_OFF, LVL_BASE, LVL_MID, LVL_HIGH} supply_lvl_e;
  typedef enum logic [1:0] {DS_IDLE, DS_KEY_HIGH, DS_KEY_MID, DS_ADDR} dev_state_e;
  typedef enum logic [1:0] {PS_IDLE, PS_ON, PS_GAP} prog_state_e;
endpackage

// >>> common/supply_link_if.sv
// supply pin link between programmer and trimmed switch
`timescale 1ns/1ns
interface supply_link_if;
  import trim_pkg::*;
  supply_lvl_e supply_lvl;
  logic        dev_out;
  modport device (input supply_lvl, output dev_out);
  modport programmer (output supply_lvl, input dev_out);
endinterface

// >>> rtl/trim_device.sv
// trimmed two-wire switch: supply-pulse decoder, fuses, chopper and comparator
//
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "trim_defs.svh"
module trim_device
  import trim_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  supply_link_if.device    link,
  input  wire logic [11:0] field_g,
  input  wire logic        high_range,
  output logic             switch_out,
  output logic [4:0]       trim_code,
  output logic             lock_blown,
  output logic             addr_mode,
  output logic             chop_clk
);

  localparam logic [8:0] CHOP_LAST = 9'(`CHOP_EDGE_CYC - 1);

  dev_state_e        state_r;
  dev_state_e        state_nxt;
  logic [8:0]        chop_cnt_r;
  logic              chop_r;
  supply_lvl_e       lvl_r;
  supply_lvl_e       peak_r;
  logic [5:0]        addr_r;
  logic [5:0]        addr_nxt;
  logic [4:0]        fuse_r;
  logic [4:0]        fuse_nxt;
  logic              lock_r;
  logic              lock_nxt;
  logic              sw_r;
  logic              out_r;

  // chopper timebase: one tick per edge of the internal clock
  wire               chop_tick = (chop_cnt_r == CHOP_LAST);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chop_cnt_r <= 9'h000;
      chop_r     <= 1'b0;
    end else if (chop_tick) begin
      chop_cnt_r <= 9'h000;
      chop_r     <= ~chop_r;
    end else begin
      chop_cnt_r <= chop_cnt_r + 9'h001;
    end
  end

  // supply level decode, sampled once per chop edge as a noise filter
  wire         dropout    = (lvl_r == LVL_OFF);
  wire         at_base    = (lvl_r == LVL_BASE);
  wire         pulse_end  = chop_tick && at_base && (peak_r != LVL_BASE);
  wire         mid_pulse  = pulse_end && (peak_r == LVL_MID);
  wire         high_pulse = pulse_end && (peak_r == LVL_HIGH);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl_r  <= LVL_OFF;
      peak_r <= LVL_BASE;
    end else if (chop_tick) begin
      lvl_r <= link.supply_lvl;
      if (at_base || dropout) begin
        peak_r <= LVL_BASE;
      end else if (lvl_r > peak_r) begin
        peak_r <= lvl_r;
      end
    end
  end

  // burn target: the low five address bits are ORed into the fuses, or the lock address sets the lock
  wire         addr_lock  = (addr_r == `LOCK_ADDR);
  wire [4:0]   burn_bits  = addr_r[4:0];
  wire         burn_now   = (state_r == DS_ADDR) && high_pulse;

  // keying and addressing sequencer
  always_comb begin
    state_nxt = state_r;
    addr_nxt  = addr_r;
    fuse_nxt  = fuse_r;
    lock_nxt  = lock_r;
    if (dropout || lock_r) begin
      state_nxt = DS_IDLE;
      addr_nxt  = 6'h00;
    end else begin
      case (state_r)
        DS_IDLE: begin
          if (high_pulse) begin
            state_nxt = DS_KEY_HIGH;
          end
        end
        DS_KEY_HIGH: begin
          if (mid_pulse) begin
            state_nxt = DS_KEY_MID;
          end
        end
        DS_KEY_MID: begin
          if (high_pulse) begin
            state_nxt = DS_ADDR;
            addr_nxt  = 6'h00;
          end else if (mid_pulse) begin
            state_nxt = DS_IDLE;
          end
        end
        DS_ADDR: begin
          if (mid_pulse && !addr_lock) begin
            addr_nxt = addr_r + 6'h01;
          end else if (burn_now) begin
            if (addr_lock) begin
              lock_nxt = 1'b1;
            end else begin
              fuse_nxt = fuse_r | burn_bits;
            end
            state_nxt = DS_IDLE;
            addr_nxt  = 6'h00;
          end
        end
        default: begin
          state_nxt = DS_IDLE;
          addr_nxt  = 6'h00;
        end
      endcase
    end
  end

  // fuses only ever set; nothing clears them but the blank-part reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= DS_IDLE;
      addr_r  <= 6'h00;
      fuse_r  <= 5'h00;
      lock_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      addr_r  <= addr_nxt;
      fuse_r  <= fuse_nxt | fuse_r;
      lock_r  <= lock_nxt | lock_r;
    end
  end

  // operate point from the fused code, release point a fixed step below
  wire [11:0]  step_lo = {4'h0, fuse_r, 3'h0};
  wire [11:0]  step_hi = {3'h0, fuse_r, 4'h0};
  wire [11:0]  op_pt   = high_range ? (`OP_BASE_HI_G + step_hi)
                                    : (`OP_BASE_LO_G + step_lo);
  wire [11:0]  rel_pt  = op_pt - `HYST_G;
  wire         above   = (field_g >= op_pt);
  wire         below   = (field_g < rel_pt);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_r <= 1'b0;
    end else if (chop_tick) begin
      if (above) begin
        sw_r <= 1'b1;
      end else if (below) begin
        sw_r <= 1'b0;
      end
    end
  end

  // outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_r      <= 1'b0;
      switch_out <= 1'b0;
      trim_code  <= 5'h00;
      lock_blown <= 1'b0;
      addr_mode  <= 1'b0;
      chop_clk   <= 1'b0;
    end else begin
      out_r      <= sw_r && !dropout;
      switch_out <= sw_r;
      trim_code  <= fuse_r;
      lock_blown <= lock_r;
      addr_mode  <= (state_r == DS_ADDR);
      chop_clk   <= chop_r;
    end
  end

  assign link.dev_out = out_r;

endmodule

// >>> rtl/trim_programmer.sv
// supply-pulse programmer with an AHB-Lite register port
`timescale 1ns/1ns
`include "trim_defs.svh"
module trim_programmer
  import trim_pkg::*;
#(
  parameter int BURN_CYCLES  = `BURN_CYC,
  parameter int PULSE_CYCLES = `PULSE_CYC,
  parameter int GAP_CYCLES   = `GAP_CYC
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  supply_link_if.programmer link
);

  localparam logic [15:0] PULSE_LAST = 16'(PULSE_CYCLES - 1);
  localparam logic [15:0] GAP_LAST   = 16'(GAP_CYCLES - 1);
  localparam logic [15:0] BURN_LAST  = 16'(BURN_CYCLES - 1);

  prog_state_e  pst_r;
  supply_lvl_e  lvl_r;
  logic [2:0]   op_r;
  logic [5:0]   left_r;
  logic [5:0]   idx_r;
  logic [15:0]  cnt_r;
  logic         wr_pend_r;
  logic [7:0]   wr_addr_r;
  logic [13:0]  cmd_r;
  logic         dev_out_r;

  // bus decode
  wire          acc      = hsel && hready && htrans[1];
  wire          rd_acc   = acc && !hwrite;
  wire          busy     = (pst_r != PS_IDLE);
  wire [31:0]   status_w = {28'h0000000, lvl_r, dev_out_r, busy};
  wire [31:0]   cmd_w    = {18'h00000, cmd_r};
  wire [31:0]   rd_mux   = (haddr[7:0] == `REG_CMD)    ? cmd_w :
                           (haddr[7:0] == `REG_STATUS) ? status_w : 32'h00000000;
  wire          cmd_wr   = wr_pend_r && (wr_addr_r == `REG_CMD) && !busy;
  wire [2:0]    new_op   = hwdata[`CMD_OP_MSB:`CMD_OP_LSB];
  wire [5:0]    new_cnt  = hwdata[`CMD_CNT_MSB:`CMD_CNT_LSB];
  wire [5:0]    n_pulses = (new_op == `OP_KEY)  ? `KEY_PULSES :
                           (new_op == `OP_ADDR) ? new_cnt : 6'h01;
  wire          start    = cmd_wr && (new_op != `OP_NONE) && (n_pulses != 6'h00);

  // level and width of the current pulse
  wire          key_mid  = (op_r == `OP_KEY) && (idx_r == 6'h01);
  wire supply_lvl_e on_lvl = (op_r == `OP_OFF) ? LVL_OFF :
                             ((op_r == `OP_ADDR) || key_mid) ? LVL_MID : LVL_HIGH;
  wire [15:0]   on_last  = (op_r == `OP_BURN) ? BURN_LAST : PULSE_LAST;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      dev_out_r <= 1'b0;
    end else begin
      wr_pend_r <= acc && hwrite;
      wr_addr_r <= haddr[7:0];
      dev_out_r <= link.dev_out;
      if (rd_acc) begin
        hrdata <= rd_mux;
      end
    end
  end

  // pulse sequencer: on phase at pulse level, then a base-level gap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pst_r  <= PS_IDLE;
      lvl_r  <= LVL_OFF;
      op_r   <= `OP_NONE;
      left_r <= 6'h00;
      idx_r  <= 6'h00;
      cnt_r  <= 16'h0000;
      cmd_r  <= 14'h0000;
    end else begin
      case (pst_r)
        PS_IDLE: begin
          lvl_r <= LVL_BASE;
          if (start) begin
            cmd_r  <= hwdata[13:0];
            op_r   <= new_op;
            left_r <= n_pulses;
            idx_r  <= 6'h00;
            cnt_r  <= 16'h0000;
            pst_r  <= PS_ON;
          end
        end
        PS_ON: begin
          lvl_r <= on_lvl;
          if (cnt_r == on_last) begin
            cnt_r  <= 16'h0000;
            left_r <= left_r - 6'h01;
            idx_r  <= idx_r + 6'h01;
            pst_r  <= PS_GAP;
          end else begin
            cnt_r <= cnt_r + 16'h0001;
          end
        end
        PS_GAP: begin
          lvl_r <= LVL_BASE;
          if (cnt_r == GAP_LAST) begin
            cnt_r <= 16'h0000;
            pst_r <= (left_r == 6'h00) ? PS_IDLE : PS_ON;
          end else begin
            cnt_r <= cnt_r + 16'h0001;
          end
        end
        default: begin
          pst_r <= PS_IDLE;
        end
      endcase
    end
  end

  // a burn command is always a single high pulse, burning the low five bits of the current address, or the lock fuse at the lock address
  assign link.supply_lvl = lvl_r;

endmodule

// >>> tb/trim_link_checker.sv
// assertions on the supply link and the trimmed switch state
`timescale 1ns/1ns
`include "trim_defs.svh"
module trim_link_checker
  import trim_pkg::*;
#(
  parameter int PULSE_MIN = `PULSE_CYC
)
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire supply_lvl_e supply_lvl,
  input wire logic [4:0]  trim_code,
  input wire logic        lock_blown,
  input wire logic        addr_mode,
  input wire logic        chop_clk
);
  localparam int chop_half = `CHOP_EDGE_CYC;
  localparam int pulse_min = PULSE_MIN;
  logic        chop_prev_r;
  logic        chop_seen_r;
  logic [8:0]  chop_cnt_r;
  logic [15:0] lvl_cnt_r;
  supply_lvl_e lvl_prev_r;
  wire         chop_chg = chop_clk != chop_prev_r;
  wire         lvl_chg = supply_lvl != lvl_prev_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chop_prev_r <= 1'b0;
      chop_seen_r <= 1'b0;
      chop_cnt_r  <= 9'h000;
      lvl_prev_r  <= LVL_OFF;
      lvl_cnt_r   <= 16'h0000;
    end else begin
      chop_prev_r <= chop_clk;
      chop_seen_r <= chop_seen_r | chop_chg;
      chop_cnt_r  <= chop_chg ? 9'h001 : chop_cnt_r + 9'h001;
      lvl_prev_r  <= supply_lvl;
      lvl_cnt_r   <= lvl_chg ? 16'h0001 : lvl_cnt_r + {15'h0000, lvl_cnt_r != 16'hFFFF};
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_base_after_reset: assert property ($rose(hresetn) |=> supply_lvl == LVL_BASE)
    else $error("supply not at base after reset");
  a_level_via_base: assert property (lvl_chg |-> lvl_prev_r == LVL_BASE || supply_lvl == LVL_BASE)
    else $error("supply skipped the base level");
  a_mid_width: assert property (lvl_chg && lvl_prev_r == LVL_MID |-> lvl_cnt_r >= pulse_min)
    else $error("mid pulse too short");
  a_fuse_kept: assert property ((trim_code & $past(trim_code)) == $past(trim_code))
    else $error("fuse bit restored");
  a_lock_kept: assert property ($past(lock_blown) |-> lock_blown)
    else $error("lock fuse restored");
  a_lock_freeze: assert property ($past(lock_blown) |-> $stable(trim_code))
    else $error("trim changed after lock");
  a_lock_no_mode: assert property ($past(lock_blown) |-> !addr_mode)
    else $error("addressing mode after lock");
  a_mode_at_base: assert property ($rose(addr_mode) |-> supply_lvl == LVL_BASE)
    else $error("addressing mode entered off base");
  a_chop_edge: assert property (chop_chg && chop_seen_r |-> chop_cnt_r == chop_half)
    else $error("chopper half period wrong");
  a_chop_alive: assert property (chop_seen_r |-> chop_cnt_r <= chop_half)
    else $error("chopper clock stalled");
endmodule

// >>> tb/supply_pulse_trim_programmer_test.sv
// self-checking bench: programmer and trimmed switch joined by the supply link
`timescale 1ns/1ns
`include "trim_defs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module supply_pulse_trim_programmer_test;
  import trim_pkg::*;
  localparam int burn_cycles = 1000;
  localparam int pulse_cycles = 600;
  typedef struct {
    logic [2:0]  op;
    logic [5:0]  cnt;
    logic [11:0] fld;
    logic        hr;
    logic [4:0]  trim;
    logic        mode;
    logic        sw;
  } row_s;
  row_s rows [14] = '{
    '{`OP_KEY, 6'h00, 12'h000, 1'b0, 5'h00, 1'b1, 1'b0},
    '{`OP_ADDR, 6'h01, 12'h000, 1'b0, 5'h00, 1'b1, 1'b0},
    '{`OP_BURN, 6'h00, 12'h000, 1'b0, 5'h01, 1'b0, 1'b0},
    '{`OP_KEY, 6'h00, 12'h000, 1'b0, 5'h01, 1'b1, 1'b0},
    '{`OP_ADDR, 6'h04, 12'h000, 1'b0, 5'h01, 1'b1, 1'b0},
    '{`OP_BURN, 6'h00, 12'h000, 1'b0, 5'h05, 1'b0, 1'b0},
    '{`OP_NONE, 6'h00, 12'h065, 1'b0, 5'h05, 1'b0, 1'b1},
    '{`OP_NONE, 6'h00, 12'h05A, 1'b0, 5'h05, 1'b0, 1'b1},
    '{`OP_NONE, 6'h00, 12'h054, 1'b0, 5'h05, 1'b0, 1'b0},
    '{`OP_NONE, 6'h00, 12'h063, 1'b0, 5'h05, 1'b0, 1'b0},
    '{`OP_NONE, 6'h00, 12'h17B, 1'b1, 5'h05, 1'b0, 1'b0},
    '{`OP_NONE, 6'h00, 12'h17D, 1'b1, 5'h05, 1'b0, 1'b1},
    '{`OP_NONE, 6'h00, 12'h16E, 1'b1, 5'h05, 1'b0, 1'b1},
    '{`OP_NONE, 6'h00, 12'h16C, 1'b1, 5'h05, 1'b0, 1'b0}};
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [11:0] field_g = 12'h000;
  logic        high_range = 1'b0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        switch_out;
  logic [4:0]  trim_code;
  logic        lock_blown;
  logic        addr_mode;
  logic        chop_clk;
  logic [31:0] r;
  int          failures = 0;
  int          compares = 0;
  always #5 hclk = ~hclk;
  supply_link_if supply_link_if_i ();
  trim_programmer #(.BURN_CYCLES(burn_cycles), .PULSE_CYCLES(pulse_cycles),
    .GAP_CYCLES(pulse_cycles)) trim_programmer_i (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata, .link(supply_link_if_i.programmer));
  trim_device trim_device_i (.hclk, .hresetn, .link(supply_link_if_i.device), .field_g,
    .high_range, .switch_out, .trim_code, .lock_blown, .addr_mode, .chop_clk);
  trim_link_checker #(.PULSE_MIN(pulse_cycles)) trim_link_checker_i (.hclk, .hresetn,
    .supply_lvl(supply_link_if_i.supply_lvl), .trim_code, .lock_blown, .addr_mode, .chop_clk);
  task automatic final_report();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= wr;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
    r = hrdata;
    if (n >= 100) begin failures++; final_report(); end
  endtask
  task automatic settle();
    int n;
    n = 0;
    do begin ahb(1'b0, 32'h4, 32'h0); n++; end while (r[0] !== 1'b0 && n < 30000);
    if (n >= 30000) begin failures++; final_report(); end
    repeat (700) @(posedge hclk);
  endtask
  task automatic cmd(input logic [2:0] op, input logic [5:0] cnt);
    ahb(1'b1, 32'h0, {18'h0, cnt, 5'h0, op});
    settle();
  endtask
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    `CHK(trim_code, 5'h00)
    `CHK(supply_link_if_i.supply_lvl, LVL_BASE)
    foreach (rows[i]) begin
      field_g <= rows[i].fld;
      high_range <= rows[i].hr;
      if (rows[i].op != `OP_NONE) cmd(rows[i].op, rows[i].cnt);
      else repeat (700) @(posedge hclk);
      `CHK(trim_code, rows[i].trim)
      `CHK(addr_mode, rows[i].mode)
      `CHK(switch_out, rows[i].sw)
      `CHK(supply_link_if_i.dev_out, rows[i].sw)
    end
    $display("test rows done");
    ahb(1'b1, 32'h0, {24'h0, 5'h0, `OP_KEY});
    ahb(1'b1, 32'h0, {18'h0, 6'h01, 5'h0, `OP_ADDR});
    ahb(1'b0, 32'h0, 32'h0);
    `CHK(r, 32'h00000001)
    settle();
    `CHK(addr_mode, 1'b1)
    cmd(`OP_ADDR, 6'h01);
    cmd(`OP_OFF, 6'h00);
    `CHK(addr_mode, 1'b0)
    cmd(`OP_ADDR, 6'h02);
    cmd(`OP_BURN, 6'h00);
    `CHK(trim_code, 5'h05)
    `CHK(lock_blown, 1'b0)
    ahb(1'b0, 32'h8, 32'h0);
    `CHK(r, 32'h00000000)
    $display("test dropout done");
    cmd(`OP_KEY, 6'h00);
    cmd(`OP_ADDR, 6'h20);
    cmd(`OP_BURN, 6'h00);
    `CHK(lock_blown, 1'b1)
    cmd(`OP_KEY, 6'h00);
    `CHK(addr_mode, 1'b0)
    `CHK(trim_code, 5'h05)
    $display("test lock done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    `CHK(trim_code, 5'h00)
    `CHK(addr_mode, 1'b0)
    `CHK(supply_link_if_i.supply_lvl, LVL_OFF)
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    `CHK(supply_link_if_i.supply_lvl, LVL_BASE)
    ahb(1'b0, 32'h4, 32'h0);
    `CHK(r, 32'h00000004)
    `CHK(hresp, 1'b0)
    $display("test reset done");
    final_report();
  end
endmodule
